// ===== cmd_decoder_pkg.sv
// constants shared by the command decoder validation block
package cmd_decoder_pkg;

   // ----------------------------------------------------------------
   // field widths
   // ----------------------------------------------------------------
   localparam int ADDR_W      = 8;
   localparam int CMD_W       = 37;
   localparam int RT_W        = 38;
   localparam int DLY_W       = 44;
   localparam int CNT_W       = 8;
   localparam int DLY_PAY_LSB = 7;
   localparam int RT_PAY_LSB  = 1;

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [CNT_W-1:0] EXEC_COUNT_RESET = 8'h00;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_HZ       = 50_000_000;
   localparam int SLOT_MS      = 15;
   localparam int SER_HZ       = 4270;
   localparam int SLOT_CYC     = (CLK_HZ / 1000) * SLOT_MS;
   localparam int SER_HALF_CYC = CLK_HZ / (2 * SER_HZ);

   // ----------------------------------------------------------------
   // state encodings
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {RT_IDLE, RT_ADDR, RT_CMD, RT_HALT} rt_state_t;
   typedef enum logic {EX_IDLE, EX_SHIFT} ex_state_t;

endpackage

// ===== cmd_decoder.sv
// command decoder: address and parity checks, time-shared execution
`timescale 1ns/1ps

module cmd_decoder
   import cmd_decoder_pkg::*;
#(
   parameter int SLOT_CYCLES = SLOT_CYC,
   parameter int SER_HALF    = SER_HALF_CYC
)(
   input  wire logic             clk,
   input  wire logic             arst_n,
   input  wire logic [1:0]       rt_clk,
   input  wire logic [1:0]       rt_data,
   input  wire logic [1:0]       rt_present,
   input  wire logic             dly_clk,
   input  wire logic             dly_data,
   input  wire logic             dly_env,
   input  wire logic             dly_in_en,
   input  wire logic             parity_disable,
   input  wire logic [ADDR_W-1:0] dec_addr,
   output logic                  ser_clk,
   output logic                  ser_data,
   output logic                  ser_env,
   output logic [CNT_W-1:0]      exec_count,
   output logic                  addr_flag,
   output logic                  parity_flag
);

   // odd parity over a whole received word
   function automatic logic parity_ok(input logic [DLY_W-1:0] w);
      parity_ok = ^w;
   endfunction

   // ----------------------------------------------------------------
   // input synchronisers
   // ----------------------------------------------------------------
   localparam int SYN_W = 19;
   logic [SYN_W-1:0] syn1;
   logic [SYN_W-1:0] syn2;
   logic [SYN_W-1:0] syn3;
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         syn1 <= '0;
         syn2 <= '0;
         syn3 <= '0;
      end else begin
         syn1 <= {dly_clk, dly_data, dly_env, dly_in_en, parity_disable,
                  rt_clk, rt_data, rt_present, dec_addr};
         syn2 <= syn1;
         syn3 <= syn2;
      end
   end
   logic              dclk_s, dclk_p, ddat_s, denv_s, denv_p, den_s, pdis_s;
   logic [1:0]        rclk_s, rclk_p, rdat_s, pres_s;
   logic [ADDR_W-1:0] addr_s;
   assign {dclk_s, ddat_s, denv_s, den_s, pdis_s,
           rclk_s, rdat_s, pres_s, addr_s} = syn2;
   assign dclk_p = syn3[18];
   assign denv_p = syn3[16];
   assign rclk_p = syn3[13:12];

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   rt_state_t          rt_state, next_rt_state;
   ex_state_t          ex_state, next_ex_state;
   logic               sel, next_sel;
   logic [RT_W-1:0]    rt_sh, next_rt_sh;
   logic [5:0]         rt_cnt, next_rt_cnt;
   logic               rt_pend, next_rt_pend;
   logic [CMD_W-1:0]   rt_buf, next_rt_buf;
   logic [DLY_W-1:0]   d_sh, next_d_sh;
   logic [5:0]         d_cnt, next_d_cnt;
   logic               st_pend, next_st_pend;
   logic [CMD_W-1:0]   st_buf, next_st_buf;
   logic [19:0]        slot_cnt, next_slot_cnt;
   logic               slot, next_slot;
   logic [CMD_W-1:0]   ex_sh, next_ex_sh;
   logic [5:0]         ex_bit, next_ex_bit;
   logic [12:0]        half, next_half;
   logic               next_ser_clk, next_ser_data, next_ser_env;
   logic [CNT_W-1:0]   next_exec_count;
   logic               next_addr_flag, next_parity_flag;
   logic               present, rt_edge, d_edge, d_end;
   logic               addr_bad, par_bad, rt_go, st_go, d_drop;
   logic [ADDR_W-1:0]  rx_addr;
   logic [RT_W-1:0]    rx_word;
   logic [DLY_W-1:0]   d_word;

   always_comb begin
      present         = pres_s[sel];
      rt_edge         = rclk_s[sel] & ~rclk_p[sel];
      d_edge          = dclk_s & ~dclk_p & denv_s & den_s;
      d_end           = denv_p & ~denv_s;
      rx_addr         = {rt_sh[ADDR_W-2:0], rdat_s[sel]};
      rx_word         = {rt_sh[RT_W-2:0], rdat_s[sel]};
      d_word          = d_sh;
      addr_bad        = 1'b0;
      par_bad         = 1'b0;
      d_drop          = 1'b0;
      next_rt_state   = rt_state;
      next_sel        = sel;
      next_rt_sh      = rt_sh;
      next_rt_cnt     = rt_cnt;
      next_rt_pend    = rt_pend;
      next_rt_buf     = rt_buf;
      next_d_sh       = d_sh;
      next_d_cnt      = d_cnt;
      next_st_pend    = st_pend;
      next_st_buf     = st_buf;
      next_addr_flag  = addr_flag;
      next_parity_flag = parity_flag;
      next_ex_state   = ex_state;
      next_ex_sh      = ex_sh;
      next_ex_bit     = ex_bit;
      next_half       = half;
      next_ser_clk    = ser_clk;
      next_ser_data   = ser_data;
      next_ser_env    = ser_env;
      next_exec_count = exec_count;

      // slot timer: even slot serves ground commands, odd slot stored
      next_slot_cnt = slot_cnt + 20'h00001;
      next_slot     = slot;
      if (slot_cnt == 20'(SLOT_CYCLES - 1)) begin
         next_slot_cnt = '0;
         next_slot     = ~slot;
      end
      rt_go = (ex_state == EX_IDLE) && !slot && rt_pend;
      st_go = (ex_state == EX_IDLE) && slot && st_pend;

      // consume before set, so a word landing now is not lost
      if (rt_go) next_rt_pend = 1'b0;
      if (st_go) next_st_pend = 1'b0;

      // ground message path
      case (rt_state)
         RT_IDLE: begin
            next_rt_cnt = '0;
            if (pres_s[0]) begin
               next_sel      = 1'b0;
               next_rt_state = RT_ADDR;
            end else if (pres_s[1]) begin
               next_sel      = 1'b1;
               next_rt_state = RT_ADDR;
            end
         end
         RT_ADDR: if (rt_edge) begin
            next_rt_sh  = rx_word;
            next_rt_cnt = rt_cnt + 6'h01;
            if (rt_cnt == 6'(ADDR_W - 1)) begin
               next_rt_cnt = '0;
               if (rx_addr == addr_s) begin
                  next_rt_state = RT_CMD;
               end else begin
                  addr_bad       = 1'b1;
                  next_addr_flag = 1'b1;
                  next_rt_state  = RT_HALT;
               end
            end
         end
         RT_CMD: if (rt_edge) begin
            next_rt_sh  = rx_word;
            next_rt_cnt = rt_cnt + 6'h01;
            if (rt_cnt == 6'(RT_W - 1)) begin
               next_rt_cnt = '0;
               if (parity_ok(DLY_W'(rx_word))) begin
                  next_rt_pend = 1'b1;
                  next_rt_buf  = rx_word[RT_W-1:RT_PAY_LSB];
               end else begin
                  par_bad          = 1'b1;
                  next_parity_flag = 1'b1;
                  next_rt_state    = RT_HALT;
               end
            end
         end
         RT_HALT: next_rt_state = RT_HALT;
         default: next_rt_state = RT_IDLE;
      endcase
      // message ends when modulation goes; that also resets the flags
      if (rt_state != RT_IDLE && !present) begin
         next_rt_state    = RT_IDLE;
         next_addr_flag   = 1'b0;
         next_parity_flag = 1'b0;
      end

      // delayed command port
      if (d_edge && d_cnt != 6'(DLY_W)) begin
         next_d_sh  = {d_sh[DLY_W-2:0], ddat_s};
         next_d_cnt = d_cnt + 6'h01;
      end
      if (d_end) begin
         next_d_cnt = '0;
         if (d_cnt == 6'(DLY_W)) begin
            if (parity_ok(d_word) || !pdis_s) begin
               next_st_pend = 1'b1;
               next_st_buf  = d_word[DLY_W-1:DLY_PAY_LSB];
            end else begin
               d_drop = 1'b1;
            end
         end
      end

      // serial command output, data moves on the falling clock edge
      case (ex_state)
         EX_IDLE: if (rt_go || st_go) begin
            next_ex_sh    = rt_go ? rt_buf : st_buf;
            next_ser_data = rt_go ? rt_buf[CMD_W-1] : st_buf[CMD_W-1];
            next_ser_env  = 1'b1;
            next_ser_clk  = 1'b0;
            next_ex_bit   = '0;
            next_half     = '0;
            next_ex_state = EX_SHIFT;
            if (rt_go) next_exec_count = exec_count + 8'h01;
         end
         EX_SHIFT: begin
            next_half = half + 13'h0001;
            if (half == 13'(SER_HALF - 1)) begin
               next_half    = '0;
               next_ser_clk = ~ser_clk;
               if (ser_clk) begin
                  if (ex_bit == 6'(CMD_W - 1)) begin
                     next_ser_env  = 1'b0;
                     next_ser_data = 1'b0;
                     next_ser_clk  = 1'b0;
                     next_ex_state = EX_IDLE;
                  end else begin
                     next_ex_bit   = ex_bit + 6'h01;
                     next_ex_sh    = {ex_sh[CMD_W-2:0], 1'b0};
                     next_ser_data = ex_sh[CMD_W-2];
                  end
               end
            end
         end
         default: next_ex_state = EX_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rt_state    <= RT_IDLE;
         ex_state    <= EX_IDLE;
         sel         <= 1'b0;
         rt_sh       <= '0;
         rt_cnt      <= '0;
         rt_pend     <= 1'b0;
         rt_buf      <= '0;
         d_sh        <= '0;
         d_cnt       <= '0;
         st_pend     <= 1'b0;
         st_buf      <= '0;
         slot_cnt    <= '0;
         slot        <= 1'b0;
         ex_sh       <= '0;
         ex_bit      <= '0;
         half        <= '0;
         ser_clk     <= 1'b0;
         ser_data    <= 1'b0;
         ser_env     <= 1'b0;
         exec_count  <= EXEC_COUNT_RESET;
         addr_flag   <= 1'b0;
         parity_flag <= 1'b0;
      end else begin
         rt_state    <= next_rt_state;
         ex_state    <= next_ex_state;
         sel         <= next_sel;
         rt_sh       <= next_rt_sh;
         rt_cnt      <= next_rt_cnt;
         rt_pend     <= next_rt_pend;
         rt_buf      <= next_rt_buf;
         d_sh        <= next_d_sh;
         d_cnt       <= next_d_cnt;
         st_pend     <= next_st_pend;
         st_buf      <= next_st_buf;
         slot_cnt    <= next_slot_cnt;
         slot        <= next_slot;
         ex_sh       <= next_ex_sh;
         ex_bit      <= next_ex_bit;
         half        <= next_half;
         ser_clk     <= next_ser_clk;
         ser_data    <= next_ser_data;
         ser_env     <= next_ser_env;
         exec_count  <= next_exec_count;
         addr_flag   <= next_addr_flag;
         parity_flag <= next_parity_flag;
      end
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);

   sequence s_addr_miss;
      addr_bad && present;
   endsequence
   property p_addr_halt;
      s_addr_miss |=> addr_flag && rt_state == RT_HALT;
   endproperty
   a_addr_halt: assert property (p_addr_halt)
      else $error("wrong address did not halt with flag");
   property p_halt_holds;
      rt_state == RT_HALT && present |=> rt_state == RT_HALT;
   endproperty
   a_halt_holds: assert property (p_halt_holds)
      else $error("halted decoder resumed without modulation loss");
   property p_parity_flag;
      par_bad && present |=> parity_flag && rt_state == RT_HALT;
   endproperty
   a_parity_flag: assert property (p_parity_flag)
      else $error("parity failure not flagged");
   property p_clear;
      rt_state != RT_IDLE && !present |=> !addr_flag && !parity_flag
         && rt_state == RT_IDLE;
   endproperty
   a_clear: assert property (p_clear)
      else $error("modulation loss did not clear flags");
   property p_flag_hold;
      addr_flag && present && rt_state != RT_IDLE |=> addr_flag;
   endproperty
   a_flag_hold: assert property (p_flag_hold)
      else $error("wrong address flag dropped early");
   property p_count;
      rt_go |=> exec_count == $past(exec_count) + 8'h01;
   endproperty
   a_count: assert property (p_count)
      else $error("execution count not incremented");
   property p_count_still;
      !rt_go |=> $stable(exec_count);
   endproperty
   a_count_still: assert property (p_count_still)
      else $error("execution count moved without a command");
   property p_slot;
      $rose(ser_env) |-> $past(rt_go) && !$past(slot)
         || $past(st_go) && $past(slot);
   endproperty
   a_slot: assert property (p_slot)
      else $error("execution started outside its slot");
   sequence s_bad_delayed;
      d_end && d_cnt == 6'(DLY_W) && pdis_s && !parity_ok(d_word);
   endsequence
   property p_withhold;
      (s_bad_delayed and (!st_pend)) |=> !st_pend;
   endproperty
   a_withhold: assert property (p_withhold)
      else $error("failed delayed command was not withheld");
   property p_env_frame;
      $rose(ser_env) |-> !ser_clk ##1 ser_env[*8];
   endproperty
   a_env_frame: assert property (p_env_frame)
      else $error("serial envelope did not frame the clock");

endmodule

// ===== cmd_source.sv
// model of the uplink receivers and the command storage processor
`timescale 1ns/1ps
module cmd_source
   import cmd_decoder_pkg::*;
(
   input  wire logic  clk,
   output logic [1:0] rt_clk,
   output logic [1:0] rt_data,
   output logic [1:0] rt_present,
   output logic       dly_clk,
   output logic       dly_data,
   output logic       dly_env,
   output logic       dly_in_en
);
   initial begin
      rt_clk = 2'b00;
      rt_data = 2'b00;
      rt_present = 2'b00;
      dly_clk = 1'b0;
      dly_data = 1'b0;
      dly_env = 1'b0;
      dly_in_en = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // ------------------------------------------------------------
   // ground link: 160 ns bit clock, stands still between bits
   // ------------------------------------------------------------
   task automatic rt_bit(input int r, input logic b);
      rt_data[r] = b;
      tick(4);
      rt_clk[r] = 1'b1;
      tick(4);
      rt_clk[r] = 1'b0;
   endtask
   task automatic rt_open(input int r, input logic [ADDR_W-1:0] a);
      rt_present[r] = 1'b1;
      tick(8);
      for (int i = ADDR_W - 1; i >= 0; i--) rt_bit(r, a[i]);
   endtask
   task automatic rt_cmd(input int r, input logic [CMD_W-1:0] p,
                         input logic bad);
      for (int i = CMD_W - 1; i >= 0; i--) rt_bit(r, p[i]);
      rt_bit(r, (~^p) ^ bad);
      // data no longer held: show the inverse, not a stale bit
      rt_data[r] = ~rt_data[r];
   endtask
   task automatic rt_close(input int r);
      rt_present[r] = 1'b0;
      tick(8);
   endtask
   // ------------------------------------------------------------
   // delayed word: payload, 6 spare, odd parity over all 44
   // ------------------------------------------------------------
   task automatic dly_word(input logic [CMD_W-1:0] p, input logic bad,
                           input int nb, input logic en);
      logic [DLY_W-1:0] w;
      w = {p, 6'h00, 1'b0};
      w[0] = (~^w) ^ bad;
      dly_in_en = en;
      dly_env = 1'b1;
      tick(4);
      for (int i = 0; i < nb; i++) begin
         dly_data = w[DLY_W-1-i];
         tick(4);
         dly_clk = 1'b1;
         tick(4);
         dly_clk = 1'b0;
      end
      tick(4);
      dly_env = 1'b0;
      dly_data = ~dly_data;
      tick(8);
   endtask
endmodule

// ===== tb.sv
// self-checking testbench of the command decoder
`timescale 1ns/1ps
module tb;
   import cmd_decoder_pkg::*;
   localparam logic [7:0] AMASK [2] = '{8'h01, 8'h80};
   // pd, bad parity, enable, due, short word
   localparam logic [4:0] DCASE [6] = '{5'b00110, 5'b11100, 5'b01110,
                                        5'b10110, 5'b00101, 5'b00000};
   logic             clk;
   logic             arst_n;
   logic             parity_disable;
   logic [ADDR_W-1:0] dec_addr;
   logic [1:0]       rt_clk;
   logic [1:0]       rt_data;
   logic [1:0]       rt_present;
   logic             dly_clk;
   logic             dly_data;
   logic             dly_env;
   logic             dly_in_en;
   logic             ser_clk;
   logic             ser_data;
   logic             ser_env;
   logic [CNT_W-1:0] exec_count;
   logic [CNT_W-1:0] exp_cnt;
   logic             addr_flag;
   logic             parity_flag;
   logic [CMD_W:0]   exp_q [$];
   logic [CMD_W:0]   ent;
   logic [CMD_W-1:0] got;
   logic [CMD_W-1:0] pay;
   logic [63:0]      rnd;
   int               nb;
   int               failures;
   int               checks_done;

   cmd_decoder #(.SLOT_CYCLES(400), .SER_HALF(4)) dut_u (
      .clk(clk), .arst_n(arst_n), .rt_clk(rt_clk), .rt_data(rt_data),
      .rt_present(rt_present), .dly_clk(dly_clk), .dly_data(dly_data),
      .dly_env(dly_env), .dly_in_en(dly_in_en),
      .parity_disable(parity_disable), .dec_addr(dec_addr),
      .ser_clk(ser_clk), .ser_data(ser_data), .ser_env(ser_env),
      .exec_count(exec_count), .addr_flag(addr_flag),
      .parity_flag(parity_flag));
   cmd_source src_u (
      .clk(clk), .rt_clk(rt_clk), .rt_data(rt_data),
      .rt_present(rt_present), .dly_clk(dly_clk), .dly_data(dly_data),
      .dly_env(dly_env), .dly_in_en(dly_in_en));

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   task automatic check(input logic ok, input string msg);
      checks_done++;
      if (ok !== 1'b1) begin
         failures++;
         $display("unexpected at %0t: %s", $time, msg);
      end
   endtask
   task automatic print_verdict;
      if (failures == 0 && checks_done > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic new_pay;
      rnd = {$urandom(), $urandom()};
      pay = rnd[CMD_W-1:0];
   endtask
   task automatic drain;
      for (int i = 0; i < 3000 && exp_q.size() > 0; i++) src_u.tick(1);
      check(exp_q.size() == 0, "command not executed");
   endtask
   task automatic gcmd(input int r, input logic bad, input logic due);
      new_pay();
      if (due) exp_q.push_back({1'b1, pay});
      src_u.rt_cmd(r, pay, bad);
   endtask
   task automatic dcmd(input logic bad, input int n, input logic en,
                       input logic due);
      new_pay();
      if (due) exp_q.push_back({1'b0, pay});
      src_u.dly_word(pay, bad, n, en);
   endtask
   task automatic good_msg(input int r);
      src_u.rt_open(r, dec_addr);
      gcmd(r, 1'b0, 1'b1);
      drain();
      src_u.rt_close(r);
   endtask

   // ------------------------------------------------------------
   // relay side: collect each serial frame, compare oldest note
   // ------------------------------------------------------------
   always @(posedge ser_env) nb = 0;
   always @(posedge ser_clk) begin
      if (ser_env === 1'b1) begin
         got = {got[CMD_W-2:0], ser_data};
         nb++;
      end
   end
   always @(negedge ser_env) begin
      if (arst_n === 1'b1) begin
         if (exp_q.size() == 0) begin
            check(1'b0, "frame with no command due");
         end else begin
            ent = exp_q.pop_front();
            if (ent[CMD_W] === 1'b1) exp_cnt = exp_cnt + 8'h01;
            check(got === ent[CMD_W-1:0], "serial payload");
            check(nb == CMD_W, "serial bit count");
            check(exec_count === exp_cnt, "execution count");
         end
      end
   end

   // ------------------------------------------------------------
   // clock, watchdog, main sequence
   // ------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   initial begin
      #1_600_000;
      failures++;
      print_verdict();
   end
   initial begin
      arst_n = 1'b0;
      parity_disable = 1'b0;
      dec_addr = 8'h00;
      exp_cnt = EXEC_COUNT_RESET;
      failures = 0;
      checks_done = 0;
      nb = 0;
      void'($urandom(32'h336f24d2));
      rnd = {$urandom(), $urandom()};
      dec_addr = rnd[ADDR_W-1:0];
      src_u.tick(5);
      arst_n = 1'b1;
      src_u.tick(5);
      check(exec_count === EXEC_COUNT_RESET && addr_flag === 1'b0 &&
            parity_flag === 1'b0 && ser_env === 1'b0, "reset");
      src_u.rt_open(0, dec_addr);
      repeat (2) begin
         gcmd(0, 1'b0, 1'b1);
         drain();
      end
      src_u.rt_close(0);
      check(addr_flag === 1'b0 && parity_flag === 1'b0, "flags");
      good_msg(1);
      for (int k = 0; k < 2; k++) begin
         src_u.rt_open(0, dec_addr ^ AMASK[k]);
         src_u.tick(4);
         check(addr_flag === 1'b1 && parity_flag === 1'b0,
               "address flag");
         gcmd(0, 1'b0, 1'b0);
         drain();
         check(addr_flag === 1'b1, "address flag held");
         src_u.rt_close(0);
         check(addr_flag === 1'b0, "address flag cleared");
      end
      src_u.rt_open(0, dec_addr);
      gcmd(0, 1'b1, 1'b0);
      src_u.tick(6);
      check(parity_flag === 1'b1 && addr_flag === 1'b0,
            "parity flag");
      gcmd(0, 1'b0, 1'b0);
      drain();
      check(parity_flag === 1'b1, "parity flag held");
      src_u.rt_close(0);
      check(parity_flag === 1'b0, "parity flag cleared");
      good_msg(0);
      for (int k = 0; k < 6; k++) begin
         parity_disable = DCASE[k][4];
         dcmd(DCASE[k][3], DCASE[k][0] ? 43 : 44, DCASE[k][2],
              DCASE[k][1]);
         drain();
      end
      // a stored word arrives after a ground command has already run in its slot
      src_u.rt_open(0, dec_addr);
      gcmd(0, 1'b0, 1'b1);
      src_u.tick(200);
      dcmd(1'b0, 44, 1'b1, 1'b1);
      drain();
      src_u.rt_close(0);
      arst_n = 1'b0;
      src_u.tick(2);
      check(exec_count === EXEC_COUNT_RESET, "count reset");
      rnd = {$urandom(), $urandom()};
      dec_addr = rnd[ADDR_W-1:0];
      arst_n = 1'b1;
      exp_cnt = EXEC_COUNT_RESET;
      src_u.tick(5);
      good_msg(0);
      print_verdict();
   end
endmodule
